// file: verilog/lcb_serial_bank.sv
/*
 * Write-only two-wire slave front end with display RAM and bank selection.
 * Assumes the bus lines arrive asynchronously and are sampled by clk; command
 * bytes are decoded outside, which reports mode, bank, pointer and subaddress loads.
 */
// Behaviour
// - Output row steps 0-3, 0-2, 0-1 or 0 depending on drive mode.
// - Static mode with alternate output bank shows row 2 instead of 0.
// - 1:2 mode with alternate output bank shows rows 2,3 instead of 0,1.
// - Alternate input bank writes row 2 (static) or rows 2,3 (1:2).
// - Input and output bank selections are held independently.
// - Two banks exist; switching acts only in static and 1:2 modes.
// - SDA falling with SCL high is START; rising is STOP.
// - Device pulls SDA low over the ninth clock after each byte it acknowledges.
// - Device only receives; its sole SDA output is acknowledge.
// - Address 0111 00x matches when bit 1 equals the select pin.
// - Reads are not answered; master sends write bit 0.
// - Mismatched devices ignore the transfer; matches acknowledge together.
// - Command bytes follow address; cleared top bit marks the last.
// - Every matched device acknowledges each command byte.
// - Later bytes are stored at pointer and subaddress, both auto-updating.
// - Data bytes are acknowledged only when subaddress pins match counter.
// - Hardware subaddress is the binary value of the three pins.
// - Pointer advances 8, 4, 3 or 2 per byte by drive mode.
// - On subaddress mismatch storage is blocked but pointer still advances.
// - Subaddress counter increments when the data pointer overflows.
`timescale 1ns/100ps
module lcb_serial_bank
	import lcb_pkg::*;
#(
	parameter int FIFO_DEPTH = LCB_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Straps
	input wire logic addr_select_pin,
	input wire logic hw_subaddr_bit0,
	input wire logic hw_subaddr_bit1,
	input wire logic hw_subaddr_bit2,
	// Command byte to external decoder
	output logic cmd_valid,
	output logic [6:0] cmd_byte,
	// Decoded command effects
	input wire logic [1:0] set_mode,
	input wire logic set_mode_en,
	input wire logic set_bank_en,
	input wire logic set_in_bank,
	input wire logic set_out_bank,
	input wire logic set_ptr_en,
	input wire logic [LCB_PTR_W-1:0] set_ptr,
	input wire logic set_sub_en,
	input wire logic [LCB_SUB_W-1:0] set_sub,
	// Display readout
	input wire logic row_step,
	input wire logic [LCB_PTR_W-1:0] rd_col,
	output logic [1:0] disp_row,
	output logic disp_bit,
	// Status
	output logic busy,
	output logic ptr_overflow
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_DATA,
		ST_ACK,
		ST_IGNORE
	} lcb_state_t;

	// Synchronisers and edge detection
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic scl_f_q;
	logic sda_f_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	lcb_state_t st_q;
	lcb_state_t ret_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic ack_q;
	logic data_phase_q;
	lcb_mode_t mode_q;
	logic in_bank_q;
	logic out_bank_q;
	logic [LCB_PTR_W-1:0] ptr_q;
	logic [LCB_SUB_W-1:0] sub_q;
	logic [3:0] ram_q [LCB_COLS];
	logic [1:0] row_q;
	logic [LCB_SUB_W-1:0] hw_sub;

	logic f_in_valid;
	logic f_in_ready;
	logic f_out_valid;
	logic [7:0] f_out_data;

	// Pointer step for the current drive mode
	function automatic logic [LCB_PTR_W-1:0] step_of(input lcb_mode_t m);
		unique case (m)
			LCB_MODE_STATIC: step_of = LCB_STEP_STATIC;
			LCB_MODE_1_2: step_of = LCB_STEP_1_2;
			LCB_MODE_1_3: step_of = LCB_STEP_1_3;
			LCB_MODE_1_4: step_of = LCB_STEP_1_4;
		endcase
	endfunction : step_of

	// Bank only matters in static and 1:2 modes
	function automatic logic [1:0] bank_row(input lcb_mode_t m, input logic b, input logic [1:0] r);
		bank_row = ((m == LCB_MODE_STATIC || m == LCB_MODE_1_2) && b) ? r + 2'd2 : r;
	endfunction : bank_row

	assign hw_sub = {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
	// Three-stage sampling; a new level counts only once stages 2 and 3 agree, so a metastable stage is never used
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_in};
			sda_s_q <= {sda_s_q[1:0], sda_in};
			scl_f_q <= (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
			sda_f_q <= (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
		end
	end

	assign scl_rise = scl_s_q[1] && scl_s_q[2] && !scl_f_q;
	assign scl_fall = !scl_s_q[1] && !scl_s_q[2] && scl_f_q;
	assign start_ev = scl_f_q && sda_f_q && !sda_s_q[1] && !sda_s_q[2];
	assign stop_ev = scl_f_q && !sda_f_q && sda_s_q[1] && sda_s_q[2];

	// Byte receiver state machine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			ret_q <= ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ack_q <= 1'b0;
			data_phase_q <= 1'b0;
		end else if (start_ev) begin
			st_q <= ST_ADDR;
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			data_phase_q <= 1'b0;
		end else if (stop_ev) begin
			st_q <= ST_IDLE;
			ack_q <= 1'b0;
			data_phase_q <= 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE, ST_IGNORE: ack_q <= 1'b0;
				ST_ADDR, ST_CMD, ST_DATA: begin
					// Data sampled on rising SCL, stable while high
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_f_q};
						bit_q <= bit_q + 4'h1;
					end
					if (scl_fall && bit_q == 4'h8) begin
						bit_q <= 4'h0;
						st_q <= ST_ACK;
						if (st_q == ST_ADDR) begin
							// Write-only: a read address is not answered
							if (sh_q[7:2] == LCB_ADDR_HI && sh_q[1] == addr_select_pin && !sh_q[0]) begin
								ack_q <= 1'b1;
								ret_q <= ST_CMD;
							end else begin
								ret_q <= ST_IGNORE;
							end
						end else if (st_q == ST_CMD) begin
							ack_q <= 1'b1;
							ret_q <= sh_q[7] ? ST_CMD : ST_DATA;
						end else begin
							ack_q <= (sub_q == hw_sub);
							ret_q <= ST_DATA;
						end
					end
				end
				ST_ACK: begin
					// Hold SDA low through the ninth high phase
					if (scl_fall) begin
						ack_q <= 1'b0;
						st_q <= ret_q;
						data_phase_q <= (ret_q == ST_DATA);
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// One-cycle push of a finished byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			f_in_valid <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_byte <= 7'h00;
		end else begin
			f_in_valid <= !start_ev && !stop_ev && st_q == ST_DATA && scl_fall && bit_q == 4'h8;
			cmd_valid <= !start_ev && !stop_ev && st_q == ST_CMD && scl_fall && bit_q == 4'h8;
			if (st_q == ST_CMD && scl_fall && bit_q == 4'h8) begin
				cmd_byte <= sh_q[6:0];
			end
		end
	end

	// Bytes wait here while the RAM writer works; a full FIFO drops a byte
	lcb_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(f_in_valid && f_in_ready),
		.in_ready(f_in_ready),
		.in_data(sh_q),
		.out_valid(f_out_valid),
		.out_ready(1'b1),
		.out_data(f_out_data)
	);

	// Mode and bank selectors, loaded only by decoded commands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= LCB_MODE_STATIC;
			in_bank_q <= LCB_BANK_RST;
			out_bank_q <= LCB_BANK_RST;
		end else begin
			if (set_mode_en) begin
				mode_q <= lcb_mode_t'(set_mode);
			end
			if (set_bank_en) begin
				in_bank_q <= set_in_bank;
				out_bank_q <= set_out_bank;
			end
		end
	end

	// Pointer and subaddress counter; pointer moves whether stored or not
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ptr_q <= '0;
			sub_q <= '0;
			ptr_overflow <= 1'b0;
		end else begin
			ptr_overflow <= 1'b0;
			if (set_ptr_en) begin
				ptr_q <= set_ptr;
			end else if (f_out_valid) begin
				ptr_q <= ptr_q + step_of(mode_q);
				if ({1'b0, ptr_q} + {1'b0, step_of(mode_q)} > 6'(LCB_COLS - 1)) begin
					sub_q <= sub_q + LCB_SUB_W'(1);
					ptr_overflow <= 1'b1;
				end
			end
			if (set_sub_en) begin
				sub_q <= set_sub;
			end
		end
	end

	// RAM fill: bits taken MSB first into rows per column
	always_ff @(posedge clk) begin
		if (f_out_valid && sub_q == hw_sub) begin
			unique case (mode_q)
				LCB_MODE_STATIC: begin
					for (int i = 0; i < 8; i++) begin
						ram_q[5'(ptr_q + 5'(i))][bank_row(mode_q, in_bank_q, 2'd0)] <= f_out_data[7-i];
					end
				end
				LCB_MODE_1_2: begin
					for (int i = 0; i < 4; i++) begin
						ram_q[5'(ptr_q + 5'(i))][bank_row(mode_q, in_bank_q, 2'd0)] <= f_out_data[7-2*i];
						ram_q[5'(ptr_q + 5'(i))][bank_row(mode_q, in_bank_q, 2'd1)] <= f_out_data[6-2*i];
					end
				end
				LCB_MODE_1_3: begin
					for (int i = 0; i < 8; i++) begin
						ram_q[5'(ptr_q + 5'(i / 3))][i % 3] <= f_out_data[7-i];
					end
				end
				LCB_MODE_1_4: begin
					for (int i = 0; i < 8; i++) begin
						ram_q[5'(ptr_q + 5'(i / 4))][i % 4] <= f_out_data[7-i];
					end
				end
			endcase
		end
	end

	// Row sequencer for the display register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			row_q <= 2'd0;
		end else if (row_step) begin
			unique case (mode_q)
				LCB_MODE_1_4: row_q <= row_q + 2'd1;
				LCB_MODE_1_3: row_q <= (row_q == 2'd2) ? 2'd0 : row_q + 2'd1;
				LCB_MODE_1_2: row_q <= (row_q == 2'd1) ? 2'd0 : 2'd1;
				LCB_MODE_STATIC: row_q <= 2'd0;
			endcase
		end else if (row_q > 2'(mode_q)) begin // Last legal row equals the mode code
			row_q <= 2'd0;
		end
	end

	// Registered display and pin outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			disp_row <= 2'd0;
			disp_bit <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			busy <= 1'b0;
		end else begin
			disp_row <= bank_row(mode_q, out_bank_q, row_q);
			disp_bit <= ram_q[rd_col][bank_row(mode_q, out_bank_q, row_q)];
			sda_out <= 1'b0;
			sda_oe <= ack_q && !start_ev && !stop_ev;
			busy <= (st_q != ST_IDLE) || data_phase_q;
		end
	end
endmodule : lcb_serial_bank

// file: common/lcb_pkg.sv
/*
 * Constants and types shared by the serial front end of the segment display driver.
 * Assumes a 125 MHz system clock and a slow two-wire bus sampled by that clock.
 */
package lcb_pkg;
	// Slave address: upper six bits fixed, bit 1 from the select pin
	localparam logic [5:0] LCB_ADDR_HI = 6'h1C;
	// Display RAM geometry
	localparam int LCB_COLS = 32;
	localparam int LCB_PTR_W = 5;
	localparam int LCB_SUB_W = 3;
	// Data pointer step per drive mode
	localparam logic [LCB_PTR_W-1:0] LCB_STEP_STATIC = 5'h08;
	localparam logic [LCB_PTR_W-1:0] LCB_STEP_1_2 = 5'h04;
	localparam logic [LCB_PTR_W-1:0] LCB_STEP_1_3 = 5'h03;
	localparam logic [LCB_PTR_W-1:0] LCB_STEP_1_4 = 5'h02;
	// Reset values of the bank selectors
	localparam logic LCB_BANK_RST = 1'b0;
	// FIFO depth between byte receiver and RAM writer
	localparam int LCB_FIFO_DEPTH = 4;
	// Drive modes set by decoded commands (encodings are supplied outside)
	typedef enum logic [1:0] {
		LCB_MODE_STATIC,
		LCB_MODE_1_2,
		LCB_MODE_1_3,
		LCB_MODE_1_4
	} lcb_mode_t;
endpackage : lcb_pkg

// file: verilog/lcb_fifo.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/100ps
module lcb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Handshakes on both sides
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : lcb_fifo

// file: dv/lcb_serial_bank_asserts.sv
/* Concurrent checks on the serial bank front end.
   Assumes a bind onto lcb_serial_bank; sees only its ports. */
`timescale 1ns/100ps
module lcb_serial_bank_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Decoder side
	input wire logic cmd_valid,
	input wire logic [1:0] set_mode,
	input wire logic set_mode_en,
	input wire logic set_bank_en,
	input wire logic set_out_bank,
	// Readout and status
	input wire logic row_step,
	input wire logic [1:0] disp_row,
	input wire logic busy,
	input wire logic ptr_overflow
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [1:0] mode_q;
	logic ob_q;
	logic row_ok;
	// Shadow of mode and output bank, as loaded by the decoder
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= 2'h0;
			ob_q <= 1'h0;
		end else begin
			if (set_mode_en) mode_q <= set_mode;
			if (set_bank_en) ob_q <= set_out_bank;
		end
	end
	// Bank only moves rows in static and 1:2
	always_comb begin
		case (mode_q)
			2'h0: row_ok = disp_row == {ob_q, 1'h0};
			2'h1: row_ok = disp_row[1] == ob_q;
			2'h2: row_ok = disp_row != 2'h3;
			default: row_ok = 1'h1;
		endcase
	end
	sequence s_ack_hold;
		sda_oe [*4];
	endsequence
	sequence s_start;
		scl_in && $fell(sda_in);
	endsequence
	sequence s_two_steps;
		row_step ##2 row_step;
	endsequence
	AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("ack raised with clock high");
	AST_ACK_HOLD: assert property (sda_oe && $rose(scl_in) |-> s_ack_hold)
		else $error("ack dropped in high phase");
	AST_SDA_OUT_LOW: assert property (sda_out == 1'h0)
		else $error("data out not low");
	AST_OE_IN_FRAME: assert property (sda_oe |-> busy)
		else $error("drive outside frame");
	AST_START_BUSY: assert property (s_start |-> ##[1:6] busy)
		else $error("start not seen");
	AST_STOP_IDLE: assert property (scl_in && $rose(sda_in) |-> ##[1:6] (!busy && !sda_oe))
		else $error("stop not seen");
	AST_CMD_ONE: assert property (cmd_valid |-> busy ##1 !cmd_valid)
		else $error("command pulse bad");
	AST_OVF_ONE: assert property (ptr_overflow |=> !ptr_overflow)
		else $error("overflow pulse long");
	AST_ROW_LEGAL: assert property (s_two_steps |-> ##2 row_ok)
		else $error("illegal row");
endmodule : lcb_serial_bank_asserts

// file: dv/lcb_master_model.sv
/* Two-wire bus master model, one byte per call.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/100ps
module lcb_master_model (
	// Bus lines
	output logic scl,
	output logic sda,
	// Resolved data line
	input wire logic sda_line
);
	// Idle bus: both lines high
	initial begin
		scl = 1'h1;
		sda = 1'h1;
	end
	// Quarter of a 125 ns bus period
	task automatic q();
		#31.25;
	endtask : q
	// Only called with the bus idle
	task automatic start();
		sda = 1'h0;
		q();
		scl = 1'h0;
		q();
	endtask : start
	// Leaves both lines high
	task automatic stop();
		sda = 1'h0;
		q();
		scl = 1'h1;
		q();
		sda = 1'h1;
		q();
		q();
	endtask : stop
	// MSB first; SDA only moves with SCL low, then released for the ack
	task automatic wr(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda = b[i];
			q();
			scl = 1'h1;
			q();
			q();
			scl = 1'h0;
			q();
		end
		sda = 1'h1;
		q();
		scl = 1'h1;
		q();
		ack = ~sda_line;
		q();
		scl = 1'h0;
		q();
	endtask : wr
endmodule : lcb_master_model

// file: dv/tb_lcb_serial_bank.sv
/* Self-checking bench for lcb_serial_bank.
   Assumes the master model and checker are compiled first. */
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %0t bad value", $time); end end
module tb_lcb_serial_bank;
	logic clk = 0, rst_n = 0, row_step = 0, sel = 0, ovf_seen = 0;
	logic [2:0] hw_sub = 3'h0, set_sub = 3'h0;
	logic [4:0] rd_col = 5'h00, set_ptr = 5'h00;
	logic [1:0] set_mode = 2'h0, disp_row;
	logic set_mode_en = 0, set_bank_en = 0, set_in_bank = 0, set_out_bank = 0, set_ptr_en = 0, set_sub_en = 0;
	logic scl, sda_m, sda, sda_out, sda_oe, cmd_valid, disp_bit, busy, ptr_overflow;
	logic [6:0] cmd_byte;
	int fail_count = 0, n_checks = 0;
	// Pull-up: low when either party pulls
	assign sda = sda_m & ~(sda_oe & ~sda_out);
	always #4 clk = ~clk;
	lcb_serial_bank lcb_serial_bank_i (.clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
		.addr_select_pin(sel), .hw_subaddr_bit0(hw_sub[0]), .hw_subaddr_bit1(hw_sub[1]),
		.hw_subaddr_bit2(hw_sub[2]), .cmd_valid, .cmd_byte, .set_mode, .set_mode_en, .set_bank_en,
		.set_in_bank, .set_out_bank, .set_ptr_en, .set_ptr, .set_sub_en, .set_sub, .row_step,
		.rd_col, .disp_row, .disp_bit, .busy, .ptr_overflow);
	lcb_master_model lcb_master_model_i (.scl, .sda(sda_m), .sda_line(sda));
	// Own command coding: kind in bits 6:5, value below
	task automatic dec(input logic [6:0] c);
		{set_mode, set_in_bank, set_out_bank, set_ptr, set_sub} = {c[1:0], c[1:0], c[4:0], c[2:0]};
		{set_mode_en, set_bank_en, set_ptr_en, set_sub_en} = 4'h8 >> c[6:5];
		@(posedge clk);
		#1;
		{set_mode_en, set_bank_en, set_ptr_en, set_sub_en} = 4'h0;
	endtask : dec
	// Decoder stand-in; sampled after the edge so the pulse has landed
	always @(posedge clk) begin
		#1;
		if (cmd_valid === 1'h1) dec(cmd_byte);
	end
	// Latch that a wrap was reported
	always @(posedge clk) if (ptr_overflow === 1'h1) ovf_seen <= 1'h1;
	// Bytes left-aligned in b, ack expectations in a, first byte at a[n-1]
	task automatic xf(input logic [63:0] b, input int n, input logic [7:0] a);
		logic k;
		lcb_master_model_i.start();
		for (int i = 0; i < n; i++) begin
			lcb_master_model_i.wr(b[63-8*i -: 8], k);
			`CHK(k, a[n-1-i])
		end
		lcb_master_model_i.stop();
		@(posedge clk);
		#1;
	endtask : xf
	// Read eight columns of the shown row, MSB at column c
	task automatic rdb(input logic [4:0] c, input logic [7:0] e);
		for (int i = 0; i < 8; i++) begin
			rd_col = c + 5'(i);
			repeat (3) @(posedge clk);
			#1;
			`CHK(disp_bit, e[7-i])
		end
	endtask : rdb
	task automatic step();
		row_step = 1'h1;
		@(posedge clk);
		#1;
		row_step = 1'h0;
		@(posedge clk);
		#1;
	endtask : step
	task automatic t_addr();
		xf(64'h7200_0000_0000_0000, 1, 8'h00);
		xf(64'h7100_0000_0000_0000, 1, 8'h00);
		sel = 1'h1;
		xf(64'h7200_0000_0000_0000, 1, 8'h01);
		sel = 1'h0;
	endtask : t_addr
	task automatic t_store();
		xf(64'h7080_C0E0_20A5_3C00, 7, 8'h7F);
		rdb(5'h00, 8'hA5);
		rdb(5'h08, 8'h3C);
		xf(64'h70C0_225A_0000_0000, 4, 8'h0F);
		rdb(5'h00, 8'hA5);
		xf(64'h7021_0000_0000_0000, 2, 8'h03);
		rdb(5'h00, 8'h5A);
		`CHK(disp_row, 2'h2)
	endtask : t_store
	task automatic t_sub();
		hw_sub = 3'h5;
		xf(64'h70A0_C864_FF00_0081, 8, 8'hF1);
		rdb(5'h00, 8'h81);
		rdb(5'h08, 8'h3C);
		`CHK(ovf_seen, 1'h1)
	endtask : t_sub
	// 1:2 mode: fill bank 1 while bank 0 shows, then switch and walk both rows
	task automatic t_duplex();
		xf(64'h7081_C022_B46C_0000, 6, 8'h3F);
		rdb(5'h00, 8'h81);
		xf(64'h7021_0000_0000_0000, 2, 8'h03);
		`CHK(disp_row, 2'h2)
		rdb(5'h00, 8'hC6);
		step();
		`CHK(disp_row, 2'h3)
		rdb(5'h00, 8'h6A);
	endtask : t_duplex
	task automatic t_rows();
		logic [3:0] mask;
		logic [3:0] e;
		for (int m = 0; m < 4; m++) begin
			for (int b = 0; b < 2; b++) begin
				dec({6'h10, b[0]});
				dec({5'h00, m[1:0]});
				mask = 4'h0;
				repeat (2) step();
				repeat (4) begin
					step();
					mask[disp_row] = 1'h1;
				end
				e = m == 3 ? 4'hF : m == 2 ? 4'h7 : m == 1 ? (b ? 4'hC : 4'h3) : (b ? 4'h4 : 4'h1);
				`CHK(mask, e)
			end
		end
	endtask : t_rows
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'h1;
		repeat (4) @(posedge clk);
		t_addr();
		t_store();
		t_sub();
		t_duplex();
		t_rows();
		test_done();
	end
	// Watchdog: the whole run needs well under 100 us
	initial begin
		#300000;
		fail_count++;
		test_done();
	end
endmodule : tb_lcb_serial_bank
bind lcb_serial_bank lcb_serial_bank_asserts lcb_serial_bank_asserts_i (.*);
